// ### testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module testbench;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, b_rd_en, go = 0, slow = 0, e = 0, w = 0;
  logic master_reset_one_n = 1, fifo1_part_reset_n = 1, fifo2_part_reset_n = 1;
  logic endian_select = 0, port_b_width_select = 0, port_c_width_select = 0;
  logic a_wr_en = 0, a_rd_en = 0, c_wr_en = 0;
  logic [35:0] a_wr_data = 36'h0, a_rd_data;
  logic [17:0] b_rd_data, c_wr_data = 18'h0;
  logic port_a_input_ready, port_a_full_flag, port_a_output_ready, port_a_empty_flag;
  logic port_b_output_ready, port_b_empty_flag, port_c_input_ready, port_c_full_flag;
  int n_errors = 0, num_checks = 0, n = 2, cnt;
  localparam logic [35:0] L = 36'h9_5A3C_1E87;

  tpb_top #(.AW(3)) dut (.*);
  tpb_b_host bh (.*);

  function automatic logic [17:0] piece(logic [35:0] l, int i);
    int k;
    k = e ? n - 1 - i : i;
    return w ? {9'h000, l[9 * k +: 9]} : l[18 * k +: 18];
  endfunction

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic mreset(logic en, logic wd);
    e = en;
    w = wd;
    n = wd ? 4 : 2;
    master_reset_one_n <= 0;
    endian_select <= en;
    port_b_width_select <= wd;
    port_c_width_select <= wd;
    repeat (2) @(posedge pclk);
    master_reset_one_n <= 1;
    repeat (3) @(posedge pclk);
  endtask

  task automatic c_put(logic [35:0] l);
    c_wr_en <= 1;
    for (int i = 0; i < n; i++) begin
      c_wr_data <= piece(l, i);
      @(posedge pclk);
    end
    c_wr_en <= 0;
  endtask

  // Slow reads leave port B stalled half the time
  task automatic drain(int k);
    bh.got_q.delete();
    slow <= (k > 1);
    go <= 1;
    for (int t = 0; t < 400 && bh.got_q.size() < k * n; t++) @(posedge pclk);
    @(posedge pclk);
    go <= 0;
    for (int j = 0; j < k * n; j++) `CHK("b_piece", piece(L + j / n, j % n), bh.got_q[j])
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial forever #4 pclk = ~pclk;

  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    give_verdict;
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    apb(0, 8'h0C, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    for (int cfg = 0; cfg < 4; cfg++) begin
      mreset(cfg[0], cfg[1]);
      apb(1, 8'h00, 32'h1);
      apb(0, 8'h04, 32'h0);
      `CHK("status", {21'h0, w, w, e, 8'h50}, rd)
      // Dangling piece must be dropped by partial reset
      c_wr_en <= 1;
      c_wr_data <= piece(L, 0);
      @(posedge pclk);
      c_wr_en <= 0;
      fifo2_part_reset_n <= 0;
      @(posedge pclk);
      fifo2_part_reset_n <= 1;
      repeat (2) @(posedge pclk);
      c_put(L);
      for (cnt = 0; cnt < 9 && port_a_output_ready !== 1'h1; cnt++) @(posedge pclk);
      `CHK("ora_time", 1'h1, cnt <= 3)
      `CHK("a_word", L, a_rd_data)
      a_rd_en <= 1;
      @(posedge pclk);
      a_rd_en <= 0;
      @(posedge pclk);
      `CHK("ora_low", 1'h0, port_a_output_ready)
      a_wr_en <= 1;
      a_wr_data <= L;
      @(posedge pclk);
      a_wr_en <= 0;
      for (cnt = 0; cnt < 9 && port_b_output_ready !== 1'h1; cnt++) @(posedge pclk);
      `CHK("orb_time", 1'h1, cnt <= 3)
      drain(1);
      `CHK("orb_low", 1'h0, port_b_output_ready)
    end
    a_wr_en <= 1;
    for (cnt = 0; cnt < 40 && port_a_input_ready === 1'h1; cnt++) begin
      a_wr_data <= L + cnt;
      @(posedge pclk);
    end
    a_wr_en <= 0;
    `CHK("fifo1_fill", 1'h1, cnt > 8)
    apb(0, 8'h08, 32'h0);
    `CHK("level", 32'h8, rd)
    drain(cnt - 1);
    `CHK("a_room", 1'h1, port_a_input_ready)
    c_wr_en <= 1;
    for (cnt = 0; cnt < 80 && port_c_input_ready === 1'h1; cnt++) begin
      c_wr_data <= piece(L, cnt % n);
      @(posedge pclk);
    end
    c_wr_en <= 0;
    `CHK("irc_fall", 0, (cnt - 1) % n)
    a_rd_en <= 1;
    @(posedge pclk);
    a_rd_en <= 0;
    repeat (3) @(posedge pclk);
    `CHK("c_room", 1'h1, port_c_input_ready)
    mreset(1, 0);
    apb(1, 8'h00, 32'h0);
    a_wr_en <= 1;
    a_wr_data <= L;
    @(posedge pclk);
    a_wr_en <= 0;
    @(posedge pclk);
    `CHK("efb_early", 1'h0, port_b_empty_flag)
    @(posedge pclk);
    `CHK("efb", 1'h1, port_b_empty_flag)
    c_put(L + 36'h1);
    @(posedge pclk);
    `CHK("efa_early", 1'h0, port_a_empty_flag)
    @(posedge pclk);
    `CHK("efa", 1'h1, port_a_empty_flag)
    a_rd_en <= 1;
    @(posedge pclk);
    a_rd_en <= 0;
    @(posedge pclk);
    `CHK("a_word_std", L + 36'h1, a_rd_data)
    `CHK("efa_low", 1'h0, port_a_empty_flag)
    `CHK("ffa", 1'h1, port_a_full_flag)
    `CHK("ffc", 1'h1, port_c_full_flag)
    drain(1);
    `CHK("efb_low", 1'h0, port_b_empty_flag)
    give_verdict;
  end
endmodule

// ### tpb_b_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port B reader, prompt or every other cycle
// ----------------------------------------
module tpb_b_host (
  input wire logic pclk,
  input wire logic go,
  input wire logic slow,
  input wire logic port_b_output_ready,
  input wire logic port_b_empty_flag,
  input wire logic [17:0] b_rd_data,
  output logic b_rd_en
);
  logic [17:0] got_q[$];
  logic took_q = 1'h0;
  initial b_rd_en = 1'h0;
  always @(posedge pclk) begin
    b_rd_en <= go && !(slow && b_rd_en);
    // Standard mode shows the piece only after its read edge
    took_q <= b_rd_en && port_b_empty_flag;
    if ((b_rd_en && port_b_output_ready) || took_q) begin
      got_q.push_back(b_rd_data);
    end
  end
endmodule

// ### tpb_consts.svh
`ifndef TPB_CONSTS_SVH
`define TPB_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TPB_CTRL_OFF 8'h00
`define TPB_STATUS_OFF 8'h04
`define TPB_LEVEL_OFF 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TPB_CTRL_FALL_THROUGH_MODE_BIT 0
`define TPB_ST_ORB_BIT 0
`define TPB_ST_EFB_BIT 1
`define TPB_ST_ORA_BIT 2
`define TPB_ST_EFA_BIT 3
`define TPB_ST_IRA_BIT 4
`define TPB_ST_FFA_BIT 5
`define TPB_ST_IRC_BIT 6
`define TPB_ST_FFC_BIT 7
`define TPB_ST_BIG_BIT 8
`define TPB_ST_BBYTE_BIT 9
`define TPB_ST_CBYTE_BIT 10
`define TPB_LVL2_LSB 16

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define TPB_CTRL_RST 1'b0
`define TPB_BYTE_PIECES 3'd4
`define TPB_WORD_PIECES 3'd2

`endif

// ### tpb_fifo_if.sv
`timescale 1ns/1ps
interface tpb_fifo_if #(
  parameter int W = 36,
  parameter int AW = 8
);
  logic push;
  logic pop;
  logic clear;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [AW:0] count;

  modport owner (output push, output pop, output clear, output wdata,
    input rdata, input count);
  modport store (input push, input pop, input clear, input wdata,
    output rdata, output count);
endinterface

// ### tpb_fifo_store.sv
`timescale 1ns/1ps
module tpb_fifo_store
  import tpb_pkg::*;
#(
  parameter int W = 36,
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  tpb_fifo_if.store f
);
  localparam int DEPTH = 1 << AW;

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;

  // Head word is read straight from the array; owner registers it
  assign f.rdata = mem_q[rd_ptr_q];
  assign f.count = count_q;

  always_ff @(posedge pclk) begin
    if (f.push) begin
      mem_q[wr_ptr_q] <= f.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (f.clear) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (f.push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (f.pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      unique case ({f.push, f.pop})
        2'b10: count_q <= count_q + 1'b1;
        2'b01: count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end
endmodule

// ### tpb_pkg.sv
package tpb_pkg;

  typedef enum logic {
    TPB_WORD = 1'b0,
    TPB_BYTE = 1'b1
  } tpb_width_t;

  typedef enum logic {
    TPB_LITTLE = 1'b0,
    TPB_BIG = 1'b1
  } tpb_endian_t;

endpackage

// ### tpb_top.sv
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tpb_consts.svh"

// What this block does
// - Word packing on C follows endian order
// - Byte packing on C: four bytes, endian order
// - Word unpacking on B: two reads, endian order
// - Byte unpacking on B: four reads, endian order
// - Upper B bits undefined during byte reads
// - FIFO1 fall-through word ready within three cycles
// - B ready falls on final piece read
// - B empty flag rises next cycle after write
// - B empty flag may lag one cycle
// - FIFO2 fall-through word ready within three cycles
// - A empty flag rises next cycle after commit
// - FIFO2 flag timing counts from completing write
// - A input ready rises next cycle after read
// - A full flag rises next cycle after read
// - FIFO1 flag timing counts from final piece read in fall-through, from first piece read in standard mode
// - C input ready rises next cycle after space
// - C ready falls on write filling FIFO2
// - Endian select caught at master reset release
// - Partial C pieces held, last commits long word
module tpb_top
  import tpb_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_reset_one_n,
  input wire logic fifo1_part_reset_n,
  input wire logic fifo2_part_reset_n,
  input wire logic endian_select,
  input wire logic port_b_width_select,
  input wire logic port_c_width_select,
  input wire logic a_wr_en,
  input wire logic [35:0] a_wr_data,
  input wire logic a_rd_en,
  output logic [35:0] a_rd_data,
  input wire logic b_rd_en,
  output logic [17:0] b_rd_data,
  input wire logic c_wr_en,
  input wire logic [17:0] c_wr_data,
  output logic port_a_input_ready,
  output logic port_a_full_flag,
  output logic port_a_output_ready,
  output logic port_a_empty_flag,
  output logic port_b_output_ready,
  output logic port_b_empty_flag,
  output logic port_c_input_ready,
  output logic port_c_full_flag
);
  localparam int DEPTH = 1 << AW;

  tpb_fifo_if #(.W(36), .AW(AW)) f1 ();
  tpb_fifo_if #(.W(36), .AW(AW)) f2 ();

  tpb_fifo_store #(.W(36), .AW(AW)) u_fifo1 (
    .pclk(pclk),
    .presetn(presetn),
    .f(f1.store)
  );

  tpb_fifo_store #(.W(36), .AW(AW)) u_fifo2 (
    .pclk(pclk),
    .presetn(presetn),
    .f(f2.store)
  );

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  logic fall_through_mode_q;
  logic mrst_seen_q;
  tpb_endian_t endian_q;
  tpb_width_t b_width;
  tpb_width_t c_width;
  logic mrst;
  logic clr1;
  logic clr2;
  logic big;
  logic [2:0] np_b;
  logic [2:0] np_c;

  // Width selects are sampled live; the user keeps them still
  assign b_width = tpb_width_t'(port_b_width_select);
  assign c_width = tpb_width_t'(port_c_width_select);
  assign mrst = !master_reset_one_n;
  assign clr1 = mrst || !fifo1_part_reset_n;
  assign clr2 = mrst || !fifo2_part_reset_n;
  assign big = (endian_q == TPB_BIG);
  assign np_b = (b_width == TPB_BYTE) ? `TPB_BYTE_PIECES : `TPB_WORD_PIECES;
  assign np_c = (c_width == TPB_BYTE) ? `TPB_BYTE_PIECES : `TPB_WORD_PIECES;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrst_seen_q <= 1'b0;
      endian_q <= TPB_LITTLE;
    end else begin
      mrst_seen_q <= master_reset_one_n;
      if (master_reset_one_n && !mrst_seen_q) begin
        endian_q <= tpb_endian_t'(endian_select);
      end
    end
  end

  // Piece k of a long word as seen on an 18-bit narrow port
  function automatic logic [17:0] piece_of(input logic [35:0] w, input logic [1:0] k,
                                           input logic is_byte, input logic is_big);
    logic [1:0] j;
    j = 2'd0;
    piece_of = 18'h00000;
    if (is_byte) begin
      j = is_big ? 2'd3 - k : k;
      // Upper bits are don't-care here; zero keeps the bus quiet
      piece_of = {9'h000, w[9*j +: 9]};
    end else begin
      j = is_big ? 2'd1 - k : k;
      piece_of = w[18*j[0] +: 18];
    end
  endfunction

  // ----------------------------------------
  // FIFO1 write, port A side
  // ----------------------------------------
  logic ira_q;
  logic ira_d;

  assign f1.push = a_wr_en && ira_q;
  assign f1.wdata = a_wr_data;
  assign f1.clear = clr1;
  // Count excludes this cycle's pop, so freed space shows one cycle on
  assign ira_d = ({1'b0, f1.count} + {{(AW + 1){1'b0}}, f1.push})
                 < (AW + 2)'(DEPTH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ira_q <= 1'b0;
    end else if (clr1) begin
      ira_q <= 1'b0;
    end else begin
      ira_q <= ira_d;
    end
  end

  assign port_a_input_ready = fall_through_mode_q & ira_q;
  assign port_a_full_flag = !fall_through_mode_q & ira_q;

  // ----------------------------------------
  // FIFO1 read, port B unpacking
  // ----------------------------------------
  logic [35:0] b_stage_q;
  logic [17:0] b_data_q;
  logic [1:0] b_cnt_q;
  logic [1:0] b_cnt_d;
  logic ob_valid_q;
  logic efb_q;
  logic b_take;
  logic b_last;
  logic nz1;

  assign nz1 = (f1.count != '0);
  assign b_last = ({1'b0, b_cnt_q} == np_b - 3'd1);
  assign b_take = fall_through_mode_q ? (b_rd_en && ob_valid_q) : (b_rd_en && efb_q);
  // Fall-through preloads the head; standard pops on the first piece
  assign f1.pop = fall_through_mode_q ? (nz1 && (!ob_valid_q || (b_take && b_last)))
                         : (b_take && b_cnt_q == 2'd0 && nz1);
  assign b_cnt_d = b_take ? (b_last ? 2'd0 : b_cnt_q + 2'd1) : b_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_cnt_q <= 2'd0;
      ob_valid_q <= 1'b0;
      efb_q <= 1'b0;
    end else if (clr1) begin
      b_cnt_q <= 2'd0;
      ob_valid_q <= 1'b0;
      efb_q <= 1'b0;
    end else begin
      b_cnt_q <= b_cnt_d;
      if (f1.pop) begin
        ob_valid_q <= 1'b1;
      end else if (b_take && b_last) begin
        ob_valid_q <= 1'b0;
      end
      efb_q <= ((f1.count - (AW + 1)'(f1.pop)) != '0) || (b_cnt_d != 2'd0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_stage_q <= 36'h000000000;
      b_data_q <= 18'h00000;
    end else begin
      if (f1.pop) begin
        b_stage_q <= f1.rdata;
      end
      if (!fall_through_mode_q) begin
        // Standard mode: the read edge loads the piece it takes
        if (b_take) begin
          b_data_q <= piece_of((b_cnt_q == 2'd0) ? f1.rdata : b_stage_q, b_cnt_q,
                               b_width == TPB_BYTE, big);
        end
      end else if (f1.pop) begin
        b_data_q <= piece_of(f1.rdata, 2'd0, b_width == TPB_BYTE, big);
      end else if (b_take && !b_last) begin
        b_data_q <= piece_of(b_stage_q, b_cnt_q + 2'd1, b_width == TPB_BYTE, big);
      end
    end
  end

  assign b_rd_data = b_data_q;
  assign port_b_output_ready = fall_through_mode_q & ob_valid_q;
  assign port_b_empty_flag = !fall_through_mode_q & efb_q;

  // ----------------------------------------
  // FIFO2 write, port C packing
  // ----------------------------------------
  logic [35:0] c_aux_q;
  logic [35:0] c_word;
  logic [1:0] c_cnt_q;
  logic [1:0] cj;
  logic irc_q;
  logic c_take;
  logic c_last;

  assign c_take = c_wr_en && irc_q;
  assign c_last = ({1'b0, c_cnt_q} == np_c - 3'd1);

  always_comb begin
    c_word = c_aux_q;
    cj = 2'd0;
    if (c_width == TPB_BYTE) begin
      cj = big ? 2'd3 - c_cnt_q : c_cnt_q;
      c_word[9*cj +: 9] = c_wr_data[8:0];
    end else begin
      cj = big ? 2'd1 - c_cnt_q : c_cnt_q;
      c_word[18*cj[0] +: 18] = c_wr_data;
    end
  end

  // Only the completing piece commits; flag timing starts from it
  assign f2.push = c_take && c_last;
  assign f2.wdata = c_word;
  assign f2.clear = clr2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_aux_q <= 36'h000000000;
      c_cnt_q <= 2'd0;
      irc_q <= 1'b0;
    end else if (clr2) begin
      c_aux_q <= 36'h000000000;
      c_cnt_q <= 2'd0;
      irc_q <= 1'b0;
    end else begin
      if (c_take) begin
        c_aux_q <= c_word;
        c_cnt_q <= c_last ? 2'd0 : c_cnt_q + 2'd1;
      end
      irc_q <= ({1'b0, f2.count} + {{(AW + 1){1'b0}}, f2.push})
               < (AW + 2)'(DEPTH);
    end
  end

  assign port_c_input_ready = fall_through_mode_q & irc_q;
  assign port_c_full_flag = !fall_through_mode_q & irc_q;

  // ----------------------------------------
  // FIFO2 read, port A
  // ----------------------------------------
  logic [35:0] a_data_q;
  logic oa_valid_q;
  logic efa_q;
  logic nz2;

  assign nz2 = (f2.count != '0);
  assign f2.pop = fall_through_mode_q ? (nz2 && (!oa_valid_q || a_rd_en))
                         : (a_rd_en && efa_q && nz2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_data_q <= 36'h000000000;
      oa_valid_q <= 1'b0;
      efa_q <= 1'b0;
    end else if (clr2) begin
      oa_valid_q <= 1'b0;
      efa_q <= 1'b0;
    end else begin
      if (f2.pop) begin
        a_data_q <= f2.rdata;
        oa_valid_q <= 1'b1;
      end else if (a_rd_en) begin
        oa_valid_q <= 1'b0;
      end
      efa_q <= (f2.count - (AW + 1)'(f2.pop)) != '0;
    end
  end

  assign a_rd_data = a_data_q;
  assign port_a_output_ready = fall_through_mode_q & oa_valid_q;
  assign port_a_empty_flag = !fall_through_mode_q & efa_q;

  // ----------------------------------------
  // APB registers
  // ----------------------------------------
  logic [31:0] prdata_q;
  logic [31:0] status;
  logic [31:0] level;
  logic hit;

  assign hit = (paddr == `TPB_CTRL_OFF) || (paddr == `TPB_STATUS_OFF)
            || (paddr == `TPB_LEVEL_OFF);

  always_comb begin
    status = 32'h00000000;
    status[`TPB_ST_ORB_BIT] = port_b_output_ready;
    status[`TPB_ST_EFB_BIT] = port_b_empty_flag;
    status[`TPB_ST_ORA_BIT] = port_a_output_ready;
    status[`TPB_ST_EFA_BIT] = port_a_empty_flag;
    status[`TPB_ST_IRA_BIT] = port_a_input_ready;
    status[`TPB_ST_FFA_BIT] = port_a_full_flag;
    status[`TPB_ST_IRC_BIT] = port_c_input_ready;
    status[`TPB_ST_FFC_BIT] = port_c_full_flag;
    status[`TPB_ST_BIG_BIT] = big;
    status[`TPB_ST_BBYTE_BIT] = port_b_width_select;
    status[`TPB_ST_CBYTE_BIT] = port_c_width_select;
    level = 32'h00000000;
    level[AW:0] = f1.count;
    level[`TPB_LVL2_LSB +: AW + 1] = f2.count;
  end

  // No wait states: read data is latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `TPB_CTRL_OFF: prdata_q <= {31'h00000000, fall_through_mode_q};
        `TPB_STATUS_OFF: prdata_q <= status;
        `TPB_LEVEL_OFF: prdata_q <= level;
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_through_mode_q <= `TPB_CTRL_RST;
    end else if (psel && penable && pwrite && paddr == `TPB_CTRL_OFF) begin
      fall_through_mode_q <= pwdata[`TPB_CTRL_FALL_THROUGH_MODE_BIT];
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
endmodule

// ### tpb_top_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module tpb_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic master_reset_one_n,
  input wire logic fifo1_part_reset_n,
  input wire logic fifo2_part_reset_n,
  input wire logic port_b_width_select,
  input wire logic a_wr_en,
  input wire logic b_rd_en,
  input wire logic c_wr_en,
  input wire logic [17:0] b_rd_data,
  input wire logic port_a_input_ready,
  input wire logic port_a_full_flag,
  input wire logic port_a_output_ready,
  input wire logic port_b_output_ready,
  input wire logic port_b_empty_flag,
  input wire logic port_c_input_ready,
  input wire logic port_c_full_flag
);
  logic a_room, c_room, b_has;
  assign a_room = port_a_input_ready | port_a_full_flag;
  assign c_room = port_c_input_ready | port_c_full_flag;
  assign b_has = port_b_output_ready | port_b_empty_flag;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  bad_addr_a: assert property (psel && penable && paddr > 8'h08 |-> pslverr)
    else $error("no error on unmapped access");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access phase");
  b_fill_time_a: assert property (a_wr_en && a_room && !b_has && !b_rd_en &&
    master_reset_one_n && fifo1_part_reset_n |-> ##[1:3] b_has)
    else $error("port b flag late after write");
  b_ready_cause_a: assert property ($rose(port_b_output_ready) |->
    $past(a_wr_en && a_room, 2))
    else $error("port b ready rose without write");
  a_ready_cause_a: assert property ($rose(port_a_output_ready) |->
    $past(c_wr_en && c_room, 2))
    else $error("port a ready rose without commit");
  a_room_fall_a: assert property ($fell(a_room) |-> $past(a_wr_en) ||
    !$past(master_reset_one_n) || !$past(fifo1_part_reset_n))
    else $error("port a room fell without write");
  c_room_fall_a: assert property ($fell(c_room) |-> $past(c_wr_en) ||
    !$past(master_reset_one_n) || !$past(fifo2_part_reset_n))
    else $error("port c room fell without write");
  byte_upper_a: assert property (port_b_width_select && port_b_output_ready |->
    b_rd_data[17:9] == 9'h000)
    else $error("upper port b bits set in byte mode");
  cover property ($fell(port_a_input_ready));
  cover property ($fell(port_c_input_ready));
  cover property ($rose(port_b_empty_flag));
endmodule

bind tpb_top tpb_top_asserts chk (.*);
